// >>> hw/redriver_pkg.sv
/*
  Shared constants and types for the signal conditioner control block.
  Assumes a single 40 MHz system clock; analog front ends deliver
  already-decoded line events and strap levels as synchronous inputs.
*/
// Behaviour
// - Enable low means reset and shutdown
// - Serial mode only if both lines high
// - Serial target at address 0x2C; data reserved
// - Attach flag rises on line pull-up
// - Attach flag falls on disconnect
// - AC boost latched only at enable rise
// - Floating AC strap selects maximum level
// - AC strap resistance decodes into four levels
// - DC strap high/float/low gives 80/60/40 mV
// - DC strap pin becomes high-speed flag output
// - Fixture then test packet raises high-speed flag
// - Chirp pair 18-128 us then squelch raises flag
// - Core regulator on only in high-speed mode
// - Low/full speed: no compensation, attach high
// - High speed: compensation with latched boosts
// - Shutdown: no compensation, no attach indication
// - Config-hold bit set in serial mode, auto-cleared otherwise
package redriver_pkg;

  localparam logic [6:0] SERIAL_ADDR = 7'h2C;
  localparam int CLK_HZ = 40000000;
  localparam int CHIRP_MIN_US = 18;
  localparam int CHIRP_MAX_US = 128;
  // Both limits are exact cycle products; no rounding is added
  localparam int CHIRP_MIN_CYC = (CHIRP_MIN_US * (CLK_HZ / 1000000) + 0);
  localparam int CHIRP_MAX_CYC = CHIRP_MAX_US * (CLK_HZ / 1000000);
  localparam int CHIRP_CNT_W = 13;

  // AC strap resistance bands in ohms
  localparam int AC_L0_MAX_OHM = 160;
  localparam int AC_L1_MIN_OHM = 1400;
  localparam int AC_L1_MAX_OHM = 2000;
  localparam int AC_L2_MIN_OHM = 3700;
  localparam int AC_L2_MAX_OHM = 3900;
  localparam int AC_L3_MIN_OHM = 6000;

  // DC strap settings in millivolts
  localparam logic [6:0] DC_LOW_MV = 7'h28;
  localparam logic [6:0] DC_MID_MV = 7'h3C;
  localparam logic [6:0] DC_HIGH_MV = 7'h50;

  localparam logic [1:0] AC_MAX_LEVEL = 2'h3;
  localparam logic CFG_HOLD_RESET = 1'b1;

  // Three-level strap as seen by the pin sensor
  typedef enum logic [1:0] {DC_PIN_LOW = 2'h0, DC_PIN_FLOAT = 2'h1, DC_PIN_HIGH = 2'h2} dc_pin_t;

  // Decoded USB line events from the analog detectors
  typedef struct packed {
    logic pullup_seen;
    logic disconnect;
    logic fixture_seen;
    logic test_packet;
    logic bus_reset;
    logic chirp_j;
    logic chirp_k;
    logic squelch;
  } line_evt_t;

  // Raw straps sampled at enable release
  typedef struct packed {
    logic scl_high;
    logic sda_high;
    logic ac_float;
    logic [15:0] ac_ohm;
    dc_pin_t dc_pin;
  } strap_in_t;

  // Channel state
  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_LSFS = 4'b0010,
    CH_CHIRP = 4'b0100,
    CH_HS = 4'b1000
  } chan_state_t;

endpackage

// >>> hw/chirp_checker.sv
/*
  Measures one chirp J followed by one chirp K after a bus reset.
  Assumes chirp levels arrive as synchronous level inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module chirp_checker
  import redriver_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronised reset
  input wire logic arm, // Start watching
  input wire logic chirp_j, // Chirp J level
  input wire logic chirp_k, // Chirp K level
  output logic pass_reg // Valid pair seen, held until rearm or a further chirp ends
);
  logic [CHIRP_CNT_W-1:0] cnt_reg;
  logic [1:0] phase_reg;
  logic last_j_reg;
  logic last_k_reg;
  wire logic in_window = (cnt_reg >= CHIRP_CNT_W'(CHIRP_MIN_CYC)) && (cnt_reg <= CHIRP_CNT_W'(CHIRP_MAX_CYC));
  wire logic j_end = last_j_reg && !chirp_j;
  wire logic k_end = last_k_reg && !chirp_k;
  wire logic counting = chirp_j || chirp_k;
  // A chirp that starts restarts the length count, so K is not added onto J
  wire logic j_start = chirp_j && !last_j_reg;
  wire logic k_start = chirp_k && !last_k_reg;

  // ----------------------------------------
  // Chirp duration check
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      phase_reg <= 2'h0;
      last_j_reg <= 1'b0;
      last_k_reg <= 1'b0;
      pass_reg <= 1'b0;
    end
    else
    begin
      last_j_reg <= chirp_j;
      last_k_reg <= chirp_k;
      if (!counting)
        cnt_reg <= '0;
      else if (j_start || k_start)
        cnt_reg <= CHIRP_CNT_W'(1'h1);
      else if (cnt_reg != '1)
        cnt_reg <= cnt_reg + 1'b1;
      if (arm)
      begin
        phase_reg <= 2'h0;
        pass_reg <= 1'b0;
      end
      else if (phase_reg == 2'h0 && j_end)
        phase_reg <= in_window ? 2'h1 : 2'h3;
      else if (phase_reg == 2'h1 && k_end)
      begin
        phase_reg <= in_window ? 2'h2 : 2'h3;
        pass_reg <= in_window;
      end
      else if (phase_reg == 2'h2 && (j_end || k_end))
      begin
        phase_reg <= 2'h3; // A second pair is not a single handshake
        pass_reg <= 1'b0;
      end
    end
  end

  a_pass_needs_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pass_reg) |-> $past(k_end) && ($past(cnt_reg) >= CHIRP_CNT_W'(CHIRP_MIN_CYC)))
    else $error("chirp pass without valid K length");
endmodule
`default_nettype wire

// >>> hw/redriver_ctrl.sv
/*
  Strap capture, mode selection and channel status flags of the
  high-speed signal conditioner.
  Assumes all inputs except nrst are synchronous to sys_clk and that analog detectors
  provide line events; the active-low enable doubles as the reset.
*/
`timescale 1ns/1ps
`default_nettype none
module redriver_ctrl
  import redriver_pkg::*;
(
  input wire logic sys_clk, // 40 MHz clock
  input wire logic nrst, // Active-low enable, asynchronous
  input wire redriver_pkg::strap_in_t straps, // Strap levels
  input wire redriver_pkg::line_evt_t line_evt, // USB line events
  input wire logic serial_hold_clear, // Serial write clearing config hold
  input wire logic [6:0] serial_addr_in, // Address seen by serial target
  output logic serial_mode, // Serial configuration active
  output logic serial_addr_hit, // Address matched in serial mode
  output logic attach_flag, // Attach flag pin level
  output logic attach_flag_oe, // Attach flag pin drive enable
  output logic hs_mode_flag, // High-speed flag pin level
  output logic hs_mode_flag_oe, // High-speed flag pin drive enable
  output logic core_regulator_out, // Core regulator enable
  output logic comp_enable, // Compensation enable
  output logic [1:0] ac_level, // Latched AC boost level
  output logic [6:0] strap_a_mv, // Latched Strap_a in mV
  output logic cfg_hold // Configuration hold bit
);
  import redriver_pkg::*;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  // Enable low forces reset at once; release is synchronised
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  wire logic [15:0] ohm = straps.ac_ohm;
  wire logic [1:0] ac_decoded =
    straps.ac_float ? AC_MAX_LEVEL :
    (ohm >= 16'(AC_L3_MIN_OHM)) ? 2'h3 :
    (ohm >= 16'(AC_L2_MIN_OHM)) ? 2'h2 :
    (ohm >= 16'(AC_L1_MIN_OHM)) ? 2'h1 : 2'h0;
  wire logic [6:0] dc_decoded =
    (straps.dc_pin == DC_PIN_HIGH) ? DC_HIGH_MV :
    (straps.dc_pin == DC_PIN_LOW) ? DC_LOW_MV : DC_MID_MV;
  wire logic serial_decoded = straps.scl_high && straps.sda_high;

  // ----------------------------------------
  // Strap capture, one clock after reset release
  // ----------------------------------------
  logic captured_reg;
  logic serial_reg;
  logic [1:0] ac_reg;
  logic [6:0] dc_reg;
  logic hold_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      captured_reg <= 1'b0;
      serial_reg <= 1'b0;
      ac_reg <= AC_MAX_LEVEL;
      dc_reg <= DC_MID_MV;
      hold_reg <= CFG_HOLD_RESET;
    end
    else if (!captured_reg)
    begin
      captured_reg <= 1'b1;
      serial_reg <= serial_decoded;
      ac_reg <= ac_decoded;
      dc_reg <= dc_decoded;
      hold_reg <= serial_decoded;
    end
    else if (serial_reg && serial_hold_clear)
      hold_reg <= 1'b0;
  end

  // ----------------------------------------
  // Channel state machine
  // ----------------------------------------
  chan_state_t state_reg;
  chan_state_t state_next;
  logic fixture_reg;
  logic chirp_ok;
  wire logic strap_run = captured_reg && !serial_reg;
  wire logic to_idle = line_evt.disconnect;

  chirp_checker u_chirp (
    .sys_clk(sys_clk),
    .rst_n(rst_n_reg),
    .arm(line_evt.bus_reset),
    .chirp_j(line_evt.chirp_j),
    .chirp_k(line_evt.chirp_k),
    .pass_reg(chirp_ok)
  );

  // Next state from line events
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CH_IDLE:
        if (line_evt.fixture_seen && line_evt.test_packet && fixture_reg)
          state_next = CH_HS;
        else if (line_evt.pullup_seen)
          state_next = CH_LSFS;
      CH_LSFS:
        if (to_idle)
          state_next = CH_IDLE;
        else if (line_evt.bus_reset)
          state_next = CH_CHIRP;
      CH_CHIRP:
        if (to_idle)
          state_next = CH_IDLE;
        else if (chirp_ok && line_evt.squelch)
          state_next = CH_HS;
        else if (line_evt.bus_reset)
          state_next = CH_CHIRP;
      CH_HS:
        if (to_idle)
          state_next = CH_IDLE;
        else if (line_evt.bus_reset)
          state_next = CH_CHIRP;
      default:
        state_next = CH_IDLE;
    endcase
  end

  // State and fixture memory, updated only while strap mode runs
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= CH_IDLE;
      fixture_reg <= 1'b0;
    end
    else if (strap_run)
    begin
      state_reg <= state_next;
      if (state_reg != CH_IDLE)
        fixture_reg <= 1'b0;
      else if (line_evt.fixture_seen)
        fixture_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  wire logic attached = state_next != CH_IDLE;
  wire logic hs_now = state_next == CH_HS;
  wire logic addr_match = serial_reg && (serial_addr_in == SERIAL_ADDR);
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      serial_mode <= 1'b0;
      serial_addr_hit <= 1'b0;
      attach_flag <= 1'b0;
      attach_flag_oe <= 1'b0;
      hs_mode_flag <= 1'b0;
      hs_mode_flag_oe <= 1'b0;
      core_regulator_out <= 1'b0;
      comp_enable <= 1'b0;
      ac_level <= AC_MAX_LEVEL;
      strap_a_mv <= DC_MID_MV;
      cfg_hold <= CFG_HOLD_RESET;
    end
    else
    begin
      serial_mode <= serial_reg && captured_reg;
      serial_addr_hit <= addr_match && captured_reg;
      attach_flag <= strap_run && attached;
      attach_flag_oe <= strap_run;
      hs_mode_flag <= strap_run && hs_now;
      hs_mode_flag_oe <= strap_run;
      core_regulator_out <= strap_run && hs_now;
      comp_enable <= strap_run && hs_now;
      ac_level <= ac_reg;
      strap_a_mv <= dc_reg;
      cfg_hold <= hold_reg;
    end
  end

  a_reg_follows_hs: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    core_regulator_out == hs_mode_flag)
    else $error("regulator and hs flag differ");
  a_comp_only_hs: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    comp_enable |-> hs_mode_flag && attach_flag)
    else $error("compensation outside hs mode");
  a_disc_clears: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (strap_run && line_evt.disconnect) |=> !attach_flag)
    else $error("attach flag held after disconnect");
  a_attach_rises: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (strap_run && state_reg == CH_IDLE && line_evt.pullup_seen) |=> attach_flag)
    else $error("attach flag not raised");
  a_boost_stable: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    $past(captured_reg) |-> $stable(ac_reg) && $stable(dc_reg))
    else $error("boost changed after capture");
  a_ac_float_max: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (!captured_reg && straps.ac_float) |=> ac_reg == AC_MAX_LEVEL)
    else $error("floating strap not max");
  a_serial_no_flags: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    serial_mode |-> !attach_flag_oe && !hs_mode_flag_oe && !cfg_hold == !$past(hold_reg))
    else $error("flags driven in serial mode");
  a_hold_strap_clear: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    (captured_reg && !serial_reg) |-> ##1 !hold_reg)
    else $error("hold not cleared in strap mode");
  a_addr_match: assert property (@(posedge sys_clk) disable iff (!rst_n_reg)
    serial_addr_hit |-> serial_mode && $past(serial_addr_in) == SERIAL_ADDR)
    else $error("wrong serial address accepted");
endmodule
`default_nettype wire

// >>> verification/usb_line_model.sv
/*
  Far-side model: a USB host and device seen through the line detectors.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_line_model
  import redriver_pkg::*;
(
  input wire logic sys_clk, // System clock
  output var redriver_pkg::line_evt_t line_evt // Line events toward the block
);
  // --------------------------------
  // Line activity
  // --------------------------------
  // Quiet lines between events
  initial line_evt = '0;

  // One-cycle event, released on the next edge
  task automatic pulse(input line_evt_t e);
    @(posedge sys_clk);
    line_evt <= e;
    @(posedge sys_clk);
    line_evt <= '0;
  endtask

  // Bus reset, one chirp J, one chirp K, then squelch
  task automatic handshake(input int j_cyc, input int k_cyc);
    pulse(8'h08);
    @(posedge sys_clk);
    line_evt <= 8'h04;
    repeat (j_cyc) @(posedge sys_clk);
    line_evt <= 8'h02;
    repeat (k_cyc) @(posedge sys_clk);
    line_evt <= '0;
    repeat (4) @(posedge sys_clk);
    pulse(8'h01);
  endtask
endmodule
`default_nettype wire

// >>> verification/hs_redriver_strap_and_status_tb.sv
/*
  Self-checking bench for the conditioner control block.
  Assumes the line model drives line events and the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module hs_redriver_strap_and_status_tb;
  import redriver_pkg::*;
  logic sys_clk, nrst, serial_hold_clear;
  strap_in_t straps;
  line_evt_t line_evt;
  logic [6:0] serial_addr_in, strap_a_mv;
  logic [1:0] ac_level;
  logic serial_mode, serial_addr_hit, attach_flag, attach_flag_oe, hs_mode_flag;
  logic hs_mode_flag_oe, core_regulator_out, comp_enable, cfg_hold;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] ohm_tab [4] = '{16'h00A0, 16'h0578, 16'h0F3C, 16'h1770};
  dc_pin_t dc_tab [4] = '{DC_PIN_LOW, DC_PIN_FLOAT, DC_PIN_HIGH, DC_PIN_LOW};
  logic [6:0] mv_tab [4] = '{7'h28, 7'h3C, 7'h50, 7'h28};

  // --------------------------------
  // Clock, partner and block
  // --------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  usb_line_model usb (.sys_clk(sys_clk), .line_evt(line_evt));

  redriver_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .straps(straps), .line_evt(line_evt),
    .serial_hold_clear(serial_hold_clear), .serial_addr_in(serial_addr_in), .serial_mode(serial_mode),
    .serial_addr_hit(serial_addr_hit), .attach_flag(attach_flag), .attach_flag_oe(attach_flag_oe),
    .hs_mode_flag(hs_mode_flag), .hs_mode_flag_oe(hs_mode_flag_oe), .core_regulator_out(core_regulator_out),
    .comp_enable(comp_enable), .ac_level(ac_level), .strap_a_mv(strap_a_mv), .cfg_hold(cfg_hold));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic strap_in_t st(input logic [1:0] i2c, input logic flt, input logic [15:0] ohm, input dc_pin_t dc);
    st = '{i2c[1], i2c[0], flt, ohm, dc};
  endfunction

  // Status flags in one compare: attach, hs, regulator, compensation
  task automatic flags(input string name, input logic [3:0] exp);
    check(name, {attach_flag, hs_mode_flag, core_regulator_out, comp_enable}, exp);
  endtask

  // Enable low for six cycles with new straps, then release
  task automatic restart(input strap_in_t s);
    @(posedge sys_clk);
    nrst <= 1'b0;
    straps <= s;
    tick(5);
    flags("flags in shutdown", 4'h0);
    check("ac in reset", ac_level, 2'h3);
    check("hold in reset", cfg_hold, 1'b1);
    @(posedge sys_clk);
    nrst <= 1'b1;
    tick(8);
  endtask

  // Cut a hung run short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin
    nrst = 1'b0;
    straps = '0;
    serial_hold_clear = 1'b0;
    serial_addr_in = 7'h00;
    for (int i = 0; i < 4; i++)
    begin
      restart(st(2'b00, 1'b0, ohm_tab[i], dc_tab[i]));
      check("ac level", ac_level, i[1:0]);
      check("dc mv", strap_a_mv, mv_tab[i]);
      check("serial mode", serial_mode, 1'b0);
      check("hold", cfg_hold, 1'b0);
      check("flag drive", {attach_flag_oe, hs_mode_flag_oe}, 2'h3);
    end
    restart(st(2'b00, 1'b1, 16'h0000, DC_PIN_FLOAT));
    check("ac float", ac_level, 2'h3);
    $display("Test straps done");
    restart(st(2'b01, 1'b0, 16'h00A0, DC_PIN_LOW));
    check("one line high", serial_mode, 1'b0);
    @(posedge sys_clk);
    straps <= st(2'b11, 1'b0, 16'h1770, DC_PIN_HIGH);
    tick(20);
    check("ac after change", ac_level, 2'h0);
    check("dc after change", strap_a_mv, 7'h28);
    usb.pulse(8'h80);
    tick(0);
    flags("low full speed", 4'h8);
    usb.handshake(800, 800);
    tick(0);
    flags("high speed", 4'hF);
    check("ac in hs", ac_level, 2'h0);
    usb.pulse(8'h40);
    tick(0);
    flags("disconnect", 4'h0);
    usb.pulse(8'h80);
    usb.handshake(100, 800);
    tick(0);
    flags("short chirp", 4'h8);
    usb.handshake(720, 4500);
    tick(0);
    flags("shortest j long k", 4'hF);
    usb.pulse(8'h40);
    usb.pulse(8'h20);
    usb.pulse(8'h30);
    tick(0);
    check("fixture hs", {hs_mode_flag, core_regulator_out}, 2'h3);
    usb.pulse(8'h40);
    $display("Test channel done");
    restart(st(2'b11, 1'b0, 16'h0F3C, DC_PIN_HIGH));
    check("serial mode", serial_mode, 1'b1);
    check("hold kept", cfg_hold, 1'b1);
    check("pins released", {attach_flag_oe, hs_mode_flag_oe}, 2'h0);
    @(posedge sys_clk);
    serial_addr_in <= 7'h2C;
    tick(2);
    check("addr hit", serial_addr_hit, 1'b1);
    @(posedge sys_clk);
    serial_addr_in <= 7'h2D;
    tick(2);
    check("addr miss", serial_addr_hit, 1'b0);
    usb.pulse(8'h80);
    tick(0);
    check("events ignored", attach_flag, 1'b0);
    @(posedge sys_clk);
    serial_hold_clear <= 1'b1;
    @(posedge sys_clk);
    serial_hold_clear <= 1'b0;
    tick(1);
    check("hold cleared", cfg_hold, 1'b0);
    $display("Test serial done");
    final_report();
  end
endmodule
`default_nettype wire
